// ### pkg/oswc_pkg.sv
// constants and types shared by the octal switch serial control block
// Notes on behaviour
// - each frame moves a 16-bit command in while a 16-bit status goes out.
// - command and status words travel most significant bit first.
// - received command takes effect only at chip select rising edge.
// - command bits 0..7 switch channels 1..8, one means on.
// - command bits 8..15 enable open-load detect current for channels 1..8.
// - status bits 8..15 always read as zero.
// - status bits 0..7 flag channel faults, one means faulted.
// - overcurrent, short to supply and overtemperature report as one.
// - open load on a channel that is on is never reported.
// - off-state open load reports only with its detect current enabled.
// - battery overvoltage forces all off; channels resume command afterwards.
// - overtemperature stops only its channel; it resumes unless commanded off.
// - sleep via enable low or logic supply loss clears all command state.
// - frame shifts out fault status captured before the frame.
// - long frame returns zeros and status, then echoes earlier input bits.
// - only frames of 16 plus multiples of 8 clocks update the command.
// - input sampled on serial clock fall, output changes on rise.
// - chip select high ignores clock and input and floats the output.
// - direct drive inputs five and six are ored with command bits.
// - chip select rise starts fault delay; open-load detect waits for it.
package oswc_pkg;
	localparam int CMD_W = 16;
	localparam int CH_N = 8;
	localparam int DET_LSB = 8;
	localparam int PWM5_IDX = 4;
	localparam int PWM6_IDX = 5;
	localparam logic [7:0] STAT_PAD = 8'h00;
	localparam logic [4:0] FRAME_MIN = 5'h10;
	localparam logic [4:0] FRAME_STEP = 5'h08;
	localparam logic [4:0] FRAME_WRAP = 5'(FRAME_MIN + FRAME_STEP - 5'h01);
	localparam logic [4:0] PAD_BITS = 5'h08;
	localparam int CLK_MHZ = 50;
	localparam int FLT_DLY_US = 300;
	localparam int FLT_DLY_CYC = FLT_DLY_US * CLK_MHZ;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_APPLY = 3'b100
	} oswc_st_e;
endpackage

// ### rtl/oswc_link.sv
// serial link shifter running on the host serial clock
`timescale 1ns/1ns
`default_nettype none
module oswc_link
	import oswc_pkg::*;
(
	input wire logic sclk_link,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic serial_in_pin,
	input wire logic [CMD_W-1:0] status_word,
	output logic serial_out,
	output logic [CMD_W-1:0] cmd_word,
	output logic frame_ok,
	output logic frame_tog
);
	logic [4:0] cnt_ff;
	logic [4:0] nxt_cnt;
	logic [CMD_W-1:0] sr_ff;
	logic [CMD_W-1:0] shift_src;
	logic do_ff;
	logic ok_ff;
	logic tog_ff;
	wire link_clr_n = rst_n & ~cs_n;
	wire first_bit = (cnt_ff == 5'h00);

	// wrapping mod-8 count past 16 keeps the length check cheap
	assign nxt_cnt = (cnt_ff == FRAME_WRAP) ? FRAME_MIN : cnt_ff + 5'h01;
	assign shift_src = first_bit ? status_word : sr_ff;

	// frame counter cleared while deselected
	always_ff @(negedge sclk_link or negedge link_clr_n) begin
		if (!link_clr_n) begin
			cnt_ff <= 5'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// one shifter serves command capture and daisy-chain echo
	always_ff @(negedge sclk_link or negedge rst_n) begin
		if (!rst_n) begin
			sr_ff <= '0;
			ok_ff <= 1'b0;
			tog_ff <= 1'b0;
		end else if (!cs_n) begin
			sr_ff <= {shift_src[CMD_W-2:0], serial_in_pin};
			ok_ff <= (nxt_cnt == FRAME_MIN);
			tog_ff <= first_bit ? ~tog_ff : tog_ff;
		end
	end

	// output bit moves on the rising edge, msb first
	always_ff @(posedge sclk_link or negedge link_clr_n) begin
		if (!link_clr_n) begin
			do_ff <= STAT_PAD[7];
		end else begin
			do_ff <= first_bit ? STAT_PAD[7] : sr_ff[CMD_W-1];
		end
	end

	assign serial_out = do_ff;
	assign cmd_word = sr_ff;
	assign frame_ok = ok_ff;
	assign frame_tog = tog_ff;

	pad_zero_a: assert property (@(negedge sclk_link) disable iff (!link_clr_n)
		(cnt_ff < PAD_BITS) |-> (serial_out == 1'b0))
		else $error("status pad bit not zero");
	echo_a: assert property (@(negedge sclk_link) disable iff (!link_clr_n)
		(cnt_ff >= FRAME_MIN) |-> (serial_out == sr_ff[CMD_W-1]))
		else $error("echo bit mismatch");
endmodule
`default_nettype wire

// ### rtl/oswc_ctrl.sv
// octal switch serial control: command apply, fault capture, sleep reset
`timescale 1ns/1ns
`default_nettype none
module oswc_ctrl
	import oswc_pkg::*;
#(
	parameter int FLT_DLY = FLT_DLY_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sclk_link,
	input wire logic cs_n,
	input wire logic serial_in_pin,
	output logic serial_out,
	output logic serial_out_oe_n,
	input wire logic enable_pin,
	input wire logic vdd_good,
	input wire logic pwm_direct_five,
	input wire logic pwm_direct_six,
	input wire logic battery_supply_over,
	input wire logic [CH_N-1:0] thermal_limit,
	input wire logic [CH_N-1:0] over_current,
	input wire logic [CH_N-1:0] open_load_cmp,
	output logic [CH_N-1:0] chan_drive,
	output logic [CH_N-1:0] detect_current_en
);
	localparam int TW = $clog2(FLT_DLY + 1);
	localparam int IN_W = 6 + 3 * CH_N + 1;
	// select resets to its idle level, so no false falling edge follows reset
	localparam logic [IN_W-1:0] SYNC_RST = {1'b0, 1'b1, {(IN_W-2){1'b0}}};

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [CH_N-1:0] gate8(input logic [CH_N-1:0] v, input logic en);
		gate8 = en ? v : '0;
	endfunction

	function automatic logic rise(input logic now, input logic prev);
		rise = now & ~prev;
	endfunction

	// ****************************************
	// declarations
	// ****************************************
	logic [IN_W-1:0] meta_ff;
	logic [IN_W-1:0] sync_ff;
	logic [IN_W-1:0] in_raw;
	logic tog_s;
	logic cs_s;
	logic en_s;
	logic vdd_s;
	logic pwm5_s;
	logic pwm6_s;
	logic ov_s;
	logic [CH_N-1:0] th_s;
	logic [CH_N-1:0] oc_s;
	logic [CH_N-1:0] ol_s;
	logic cs_prev_ff;
	logic tog_seen_ff;
	oswc_st_e st_ff;
	oswc_st_e nxt_st;
	logic [CMD_W-1:0] cmd_ff;
	logic [CMD_W-1:0] nxt_cmd;
	logic [CH_N-1:0] drive_ff;
	logic [CH_N-1:0] nxt_drive;
	logic [CH_N-1:0] olcur_ff;
	logic [CH_N-1:0] latch_ff;
	logic [CH_N-1:0] nxt_latch;
	logic [CH_N-1:0] snap_ff;
	logic [TW-1:0] tmr_ff;
	logic [TW-1:0] nxt_tmr;
	logic [CMD_W-1:0] link_cmd;
	logic link_ok;
	logic link_tog;
	logic [CMD_W-1:0] status_word;

	// ****************************************
	// pin synchronisers
	// ****************************************
	assign in_raw = {link_tog, cs_n, enable_pin, vdd_good, pwm_direct_five,
		pwm_direct_six, battery_supply_over, thermal_limit, over_current, open_load_cmp};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= SYNC_RST;
			sync_ff <= SYNC_RST;
		end else begin
			meta_ff <= in_raw;
			sync_ff <= meta_ff;
		end
	end

	assign tog_s = sync_ff[IN_W-1];
	assign cs_s = sync_ff[IN_W-2];
	assign en_s = sync_ff[IN_W-3];
	assign vdd_s = sync_ff[IN_W-4];
	assign pwm5_s = sync_ff[IN_W-5];
	assign pwm6_s = sync_ff[IN_W-6];
	assign ov_s = sync_ff[3*CH_N];
	assign th_s = sync_ff[3*CH_N-1:2*CH_N];
	assign oc_s = sync_ff[2*CH_N-1:CH_N];
	assign ol_s = sync_ff[CH_N-1:0];

	// ****************************************
	// frame events
	// ****************************************
	wire sleep = ~en_s | ~vdd_s;
	wire cs_rise = rise(cs_s, cs_prev_ff);
	wire cs_fall = rise(cs_prev_ff, cs_s);
	// a toggle that did not move means no clock reached the link this frame
	wire fresh = (tog_s != tog_seen_ff);
	// link words are quiet here: select is high and the clock is parked
	wire accept = (st_ff == ST_APPLY) & link_ok & fresh & ~sleep;
	wire tmr_done = (tmr_ff == '0);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev_ff <= 1'b1;
			tog_seen_ff <= 1'b0;
		end else begin
			cs_prev_ff <= cs_s;
			tog_seen_ff <= (st_ff == ST_APPLY) ? tog_s : tog_seen_ff;
		end
	end

	// ****************************************
	// frame sequencer
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			ST_IDLE: begin
				if (cs_fall) begin
					nxt_st = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (cs_rise) begin
					nxt_st = ST_APPLY;
				end
			end
			ST_APPLY: begin
				nxt_st = ST_IDLE;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// command word
	// ****************************************
	assign nxt_cmd = sleep ? '0 : (accept ? link_cmd : cmd_ff);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff <= '0;
		end else begin
			cmd_ff <= nxt_cmd;
		end
	end

	// ****************************************
	// fault delay timer
	// ****************************************
	assign nxt_tmr = (st_ff == ST_APPLY) ? TW'(FLT_DLY) :
		(tmr_done ? tmr_ff : tmr_ff - TW'(1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tmr_ff <= '0;
		end else begin
			tmr_ff <= nxt_tmr;
		end
	end

	// ****************************************
	// channel drive
	// ****************************************
	wire [CH_N-1:0] pwm_or = CH_N'({pwm6_s, pwm5_s}) << PWM5_IDX;
	wire [CH_N-1:0] want_on = cmd_ff[CH_N-1:0] | pwm_or;
	// thermal stop is live, so a cooled channel returns on its own
	assign nxt_drive = gate8(want_on & ~th_s, ~ov_s & ~sleep);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			drive_ff <= '0;
			olcur_ff <= '0;
		end else begin
			drive_ff <= nxt_drive;
			olcur_ff <= gate8(cmd_ff[CMD_W-1:DET_LSB], ~sleep);
		end
	end

	assign chan_drive = drive_ff;
	assign detect_current_en = olcur_ff;

	// ****************************************
	// fault capture
	// ****************************************
	wire [CH_N-1:0] ol_flag = gate8(ol_s & ~drive_ff & olcur_ff, tmr_done);
	wire [CH_N-1:0] live = gate8(oc_s | th_s | ol_flag, ~sleep);
	// new faults in the snapshot cycle stay latched for the next frame
	assign nxt_latch = sleep ? '0 : (cs_fall ? live : latch_ff | live);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latch_ff <= '0;
			snap_ff <= '0;
		end else begin
			latch_ff <= nxt_latch;
			snap_ff <= cs_fall ? (latch_ff | live) : snap_ff;
		end
	end

	assign status_word = {STAT_PAD, snap_ff};

	// ****************************************
	// serial link
	// ****************************************
	oswc_link u_link (
		.sclk_link(sclk_link),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.serial_in_pin(serial_in_pin),
		.status_word(status_word),
		.serial_out(serial_out),
		.cmd_word(link_cmd),
		.frame_ok(link_ok),
		.frame_tog(link_tog)
	);

	// driver enable follows the select pin with no delay
	assign serial_out_oe_n = cs_n;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	cmd_apply_a: assert property (accept |=> cmd_ff == $past(link_cmd))
		else $error("accepted command not applied");
	cmd_hold_a: assert property ((st_ff != ST_APPLY) && !sleep |=> $stable(cmd_ff))
		else $error("command changed outside chip select rise");
	bad_len_a: assert property ((st_ff == ST_APPLY) && !link_ok |=> $stable(cmd_ff))
		else $error("bad frame length changed command");
	drive_map_a: assert property (!sleep && !ov_s && th_s == '0 && pwm_or == '0
		|=> drive_ff == $past(cmd_ff[CH_N-1:0]))
		else $error("channel drive does not follow command");
	pwm_or_a: assert property (pwm5_s && !sleep && !ov_s && !th_s[PWM5_IDX]
		|=> drive_ff[PWM5_IDX])
		else $error("direct drive five ignored");
	ov_off_a: assert property (ov_s |=> drive_ff == '0)
		else $error("overvoltage left a channel on");
	ov_resume_a: assert property (ov_s ##1 (!ov_s && !sleep && th_s == '0 && $stable(cmd_ff))
		|=> drive_ff == $past(cmd_ff[CH_N-1:0] | pwm_or))
		else $error("channels did not resume after overvoltage");
	therm_off_a: assert property (##1 (drive_ff & $past(th_s)) == '0)
		else $error("hot channel still driven");
	sleep_clr_a: assert property (sleep |=> cmd_ff == '0 && drive_ff == '0 ##1 olcur_ff == '0)
		else $error("sleep did not clear state");
	ol_on_a: assert property ((ol_flag & drive_ff) == '0)
		else $error("open load reported on an on channel");
	ol_dis_a: assert property ((ol_flag & ~olcur_ff) == '0)
		else $error("open load reported with current off");
	snap_a: assert property (cs_fall |=> snap_ff == $past(latch_ff | live))
		else $error("status snapshot wrong");
	delay_a: assert property ((st_ff == ST_APPLY) |=> ol_flag == '0 [*8])
		else $error("open load reported inside fault delay");
	oc_rep_a: assert property (cs_fall && oc_s[0] && !sleep |=> snap_ff[0])
		else $error("overcurrent not reported");
	det_map_a: assert property (!sleep |=> olcur_ff == $past(cmd_ff[CMD_W-1:DET_LSB]))
		else $error("detect current does not follow command");
	latch_set_a: assert property (!sleep |=> (latch_ff & $past(live)) == $past(live))
		else $error("new fault lost from the latch");
	tmr_load_a: assert property ((st_ff == ST_APPLY) |=> tmr_ff == TW'(FLT_DLY))
		else $error("fault delay not restarted");
	stat_pad_a: assert property (status_word[CMD_W-1:CH_N] == STAT_PAD)
		else $error("status pad bits not zero");
	therm_back_a: assert property (!sleep && !ov_s
		|=> drive_ff == $past((cmd_ff[CH_N-1:0] | pwm_or) & ~th_s))
		else $error("cooled channel not restored");

	accept_c: cover property (accept);
	reject_c: cover property ((st_ff == ST_APPLY) && !link_ok && fresh);
	ov_c: cover property (ov_s ##1 !ov_s);
	therm_c: cover property (th_s[0] && cmd_ff[0] ##1 !th_s[0]);
	sleep_c: cover property (sleep ##1 !sleep);
endmodule
`default_nettype wire

// ### tb/oswc_host.sv
// host serial master model for the switch block link
`timescale 1ns/1ns
`default_nettype none
module oswc_host
(
	output logic sclk_link,
	output logic cs_n,
	output logic serial_in_pin,
	input wire logic serial_line
);
	initial begin
		sclk_link = 1'b0;
		cs_n = 1'b1;
		serial_in_pin = 1'b0;
	end
	// clock stands low outside frames, so select only moves with it low
	task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		#3 cs_n = 1'b0;
		#100;
		for (int i = n - 1; i >= 0; i--) begin
			sclk_link = 1'b1;
			serial_in_pin = tx[i];
			#24 rx = {rx[30:0], serial_line};
			sclk_link = 1'b0;
			#24;
		end
		cs_n = 1'b1;
		// released data line shows the inverse, not a stale value
		serial_in_pin = ~serial_in_pin;
		#500;
	endtask
endmodule
`default_nettype wire

// ### tb/oswc_ctrl_tb.sv
// self-checking bench for the octal switch serial control block
`timescale 1ns/1ns
`default_nettype none
module oswc_ctrl_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic enable_pin = 1'b1;
	logic vdd_good = 1'b1;
	logic pwm_direct_five = 1'b0;
	logic pwm_direct_six = 1'b0;
	logic battery_supply_over = 1'b0;
	logic [7:0] thermal_limit = 8'h00;
	logic [7:0] over_current = 8'h00;
	logic [7:0] open_load_cmp = 8'h00;
	logic [7:0] chan_drive;
	logic [7:0] detect_current_en;
	logic sclk_link;
	logic cs_n;
	logic serial_in_pin;
	logic serial_out;
	logic serial_out_oe_n;
	logic so_last = 1'b0;
	logic [31:0] rx;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	wire serial_line = serial_out_oe_n ? ~so_last : serial_out;

	// ****************************************
	// clock, wire, instances
	// ****************************************
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(serial_out or serial_out_oe_n) begin
		if (!serial_out_oe_n) so_last = serial_out;
	end
	oswc_ctrl #(.FLT_DLY(20)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sclk_link(sclk_link), .cs_n(cs_n),
		.serial_in_pin(serial_in_pin), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
		.enable_pin(enable_pin), .vdd_good(vdd_good), .pwm_direct_five(pwm_direct_five),
		.pwm_direct_six(pwm_direct_six), .battery_supply_over(battery_supply_over),
		.thermal_limit(thermal_limit), .over_current(over_current), .open_load_cmp(open_load_cmp),
		.chan_drive(chan_drive), .detect_current_en(detect_current_en));
	oswc_host host_u (.sclk_link(sclk_link), .cs_n(cs_n), .serial_in_pin(serial_in_pin),
		.serial_line(serial_line));

	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic t_reset;
		chk("drive", 8'h00, chan_drive);
		chk("detect", 8'h00, detect_current_en);
		chk("oe_n idle", 1'b1, serial_out_oe_n);
		$display("t_reset done");
	endtask
	task automatic t_cmd;
		fork
			host_u.frame(16, 32'ha53c, rx);
			#400 chk("drive mid frame", 8'h00, chan_drive);
		join
		w(10);
		chk("drive", 8'h3c, chan_drive);
		chk("detect", 8'ha5, detect_current_en);
		chk("status", 16'h0000, rx[15:0]);
		$display("t_cmd done");
	endtask
	// off+detect on: ch1, ch8 flagged; ch2, ch7 detect off; ch3 on
	task automatic t_fault;
		@(posedge clk_sys);
		open_load_cmp <= 8'hc7;
		over_current <= 8'h10;
		thermal_limit <= 8'h08;
		w(40);
		chk("thermal off", 8'h34, chan_drive);
		host_u.frame(16, 32'ha53c, rx);
		chk("status", 16'h0099, rx[15:0]);
		chk("on faults", 8'h18, rx[7:0] & 8'h3c);
		chk("off faults", 8'h81, rx[7:0] & ~8'h3c);
		@(posedge clk_sys);
		thermal_limit <= 8'h00;
		open_load_cmp <= 8'h00;
		over_current <= 8'h00;
		w(10);
		chk("thermal back", 8'h3c, chan_drive);
		battery_supply_over <= 1'b1;
		w(10);
		chk("overvoltage off", 8'h00, chan_drive);
		battery_supply_over <= 1'b0;
		w(10);
		chk("overvoltage back", 8'h3c, chan_drive);
		$display("t_fault done");
	endtask
	task automatic t_frames;
		host_u.frame(32, 32'h123400f0, rx);
		w(10);
		chk("pad", 8'h00, rx[31:24]);
		chk("echo", 16'h1234, rx[15:0]);
		chk("drive", 8'hf0, chan_drive);
		chk("detect", 8'h00, detect_current_en);
		host_u.frame(20, 32'h000ff, rx);
		w(10);
		chk("len 20", 8'hf0, chan_drive);
		host_u.frame(24, 32'h0000ff, rx);
		w(10);
		chk("len 24", 8'hff, chan_drive);
		host_u.frame(15, 32'h0, rx);
		w(10);
		chk("len 15", 8'hff, chan_drive);
		$display("t_frames done");
	endtask
	task automatic t_pwm;
		host_u.frame(16, 32'h0, rx);
		@(posedge clk_sys);
		pwm_direct_five <= 1'b1;
		pwm_direct_six <= 1'b1;
		w(10);
		chk("direct", 8'h30, chan_drive);
		pwm_direct_five <= 1'b0;
		pwm_direct_six <= 1'b0;
		w(10);
		chk("direct off", 8'h00, chan_drive);
		$display("t_pwm done");
	endtask
	// commands left on before sleep on purpose, the awkward case
	task automatic t_sleep;
		for (int i = 0; i < 2; i++) begin
			host_u.frame(16, 32'hffff, rx);
			w(10);
			if (i == 0) enable_pin <= 1'b0;
			else vdd_good <= 1'b0;
			w(8);
			chk("sleep drive", 8'h00, chan_drive);
			enable_pin <= 1'b1;
			vdd_good <= 1'b1;
			w(8);
			chk("wake detect", 8'h00, detect_current_en);
			chk("wake drive", 8'h00, chan_drive);
		end
		host_u.frame(16, 32'h0000, rx);
		w(10);
		enable_pin <= 1'b0;
		w(8);
		chk("quiet sleep drive", 8'h00, chan_drive);
		enable_pin <= 1'b1;
		w(8);
		chk("quiet wake detect", 8'h00, detect_current_en);
		$display("t_sleep done");
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("unexpected cycles expected below %0d seen %0d", 20000, cyc);
			end_of_test();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		w(4);
		t_reset();
		t_cmd();
		t_fault();
		t_frames();
		t_pwm();
		t_sleep();
		end_of_test();
	end
endmodule
`default_nettype wire
